// [cpu_ctl_pkg.sv]
package cpu_ctl_pkg;
  localparam int PC_W = 20;
  localparam int CNT_W = 4;

  // Instruction selector codes presented by the fetch stage
  localparam logic [3:0] OP_BR_CLR = 4'h0;
  localparam logic [3:0] OP_BR_SET = 4'h1;
  localparam logic [3:0] OP_SK_CARRY = 4'h2;
  localparam logic [3:0] OP_SK_NCARRY = 4'h3;
  localparam logic [3:0] OP_SKZ = 4'h4;
  localparam logic [3:0] OP_SKNZ = 4'h5;
  localparam logic [3:0] OP_SKH = 4'h6;
  localparam logic [3:0] OP_SKNH = 4'h7;
  localparam logic [3:0] OP_SEL = 4'h8;
  localparam logic [3:0] OP_NOP = 4'h9;
  localparam logic [3:0] OP_INT_ON = 4'ha;
  localparam logic [3:0] OP_INT_OFF = 4'hb;
  localparam logic [3:0] OP_HALT = 4'hc;
  localparam logic [3:0] OP_STOP = 4'hd;

  // Bit operand addressing variants
  localparam logic [2:0] M_SADDR = 3'h0;
  localparam logic [2:0] M_SFR = 3'h1;
  localparam logic [2:0] M_ACC = 3'h2;
  localparam logic [2:0] M_STAT = 3'h3;
  localparam logic [2:0] M_PTR = 3'h4;
  localparam logic [2:0] M_ESHL = 3'h5;

  // Status word layout
  localparam int SW_CARRY = 0;
  localparam int SW_BANK0 = 3;
  localparam int SW_HALF = 4;
  localparam int SW_BANK1 = 5;
  localparam int SW_ZERO = 6;
  localparam int SW_INTEN = 7;
  localparam logic [7:0] SW_RST = 8'h00;

  // Encoding lengths in bytes
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;

  // Clock counts: not met / met pairs, then single counts used for both
  localparam logic [CNT_W-1:0] CLK_BIT_NM = 4'h3;
  localparam logic [CNT_W-1:0] CLK_BIT_M = 4'h5;
  localparam logic [CNT_W-1:0] CLK_ES_NM = 4'h4;
  localparam logic [CNT_W-1:0] CLK_ES_M = 4'h6;
  localparam logic [CNT_W-1:0] CLK_PM_HL_NM = 4'h6;
  localparam logic [CNT_W-1:0] CLK_PM_HL_M = 4'h7;
  localparam logic [CNT_W-1:0] CLK_PM_ES_NM = 4'h7;
  localparam logic [CNT_W-1:0] CLK_PM_ES_M = 4'h8;
  localparam logic [CNT_W-1:0] CLK_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CLK_INT = 4'h4;
  localparam logic [CNT_W-1:0] CLK_LP = 4'h3;
endpackage : cpu_ctl_pkg

// [instr_timing.sv]
`timescale 1ns/100ps
module instr_timing (
  input wire logic [3:0] op,
  input wire logic [2:0] mode,
  input wire logic prog_area,
  output logic [2:0] len,
  output logic [cpu_ctl_pkg::CNT_W-1:0] clk_nm,
  output logic [cpu_ctl_pkg::CNT_W-1:0] clk_m,
  output logic needs_mem
);
  logic bit_op;
  logic short_enc;

  always_comb begin
    bit_op = (op == cpu_ctl_pkg::OP_BR_CLR) || (op == cpu_ctl_pkg::OP_BR_SET);
    short_enc = (mode == cpu_ctl_pkg::M_ACC) || (mode == cpu_ctl_pkg::M_PTR);
    needs_mem = bit_op && (mode != cpu_ctl_pkg::M_ACC) && (mode != cpu_ctl_pkg::M_STAT);
    len = cpu_ctl_pkg::LEN_2;
    clk_nm = cpu_ctl_pkg::CLK_ONE;
    clk_m = cpu_ctl_pkg::CLK_ONE;
    if (bit_op) begin
      len = short_enc ? cpu_ctl_pkg::LEN_3 : cpu_ctl_pkg::LEN_4;
      clk_nm = cpu_ctl_pkg::CLK_BIT_NM;
      clk_m = cpu_ctl_pkg::CLK_BIT_M;
      if (mode == cpu_ctl_pkg::M_ESHL) begin
        clk_nm = cpu_ctl_pkg::CLK_ES_NM;
        clk_m = cpu_ctl_pkg::CLK_ES_M;
      end
      // Program memory column exists only for the clear-test branch
      if (prog_area && op == cpu_ctl_pkg::OP_BR_CLR) begin
        if (mode == cpu_ctl_pkg::M_PTR) begin
          clk_nm = cpu_ctl_pkg::CLK_PM_HL_NM;
          clk_m = cpu_ctl_pkg::CLK_PM_HL_M;
        end else if (mode == cpu_ctl_pkg::M_ESHL) begin
          clk_nm = cpu_ctl_pkg::CLK_PM_ES_NM;
          clk_m = cpu_ctl_pkg::CLK_PM_ES_M;
        end
      end
    end else begin
      case (op)
        cpu_ctl_pkg::OP_NOP: begin
          len = cpu_ctl_pkg::LEN_1;
        end
        cpu_ctl_pkg::OP_INT_ON, cpu_ctl_pkg::OP_INT_OFF: begin
          len = cpu_ctl_pkg::LEN_3;
          clk_nm = cpu_ctl_pkg::CLK_INT;
          clk_m = cpu_ctl_pkg::CLK_INT;
        end
        cpu_ctl_pkg::OP_HALT, cpu_ctl_pkg::OP_STOP: begin
          clk_nm = cpu_ctl_pkg::CLK_LP;
          clk_m = cpu_ctl_pkg::CLK_LP;
        end
        default: begin
          len = cpu_ctl_pkg::LEN_2;
        end
      endcase
    end
  end
endmodule : instr_timing

// [bit_branch_skip_cpu_control.sv]
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module bit_branch_skip_cpu_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [3:0] op,
  input wire logic [2:0] mode,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] rel_ofs,
  input wire logic [cpu_ctl_pkg::PC_W-1:0] instr_addr,
  input wire logic [cpu_ctl_pkg::PC_W-1:0] eff_addr,
  input wire logic prog_area,
  input wire logic [7:0] acc_in,
  input wire logic sw_ld,
  input wire logic [7:0] sw_wdata,
  input wire logic wake,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic [cpu_ctl_pkg::PC_W-1:0] next_pc,
  output logic skip_next,
  output logic mem_rd,
  output logic mem_wr,
  output logic [cpu_ctl_pkg::PC_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic acc_wr,
  output logic [7:0] acc_wdata,
  output logic [7:0] program_status_word,
  output logic [1:0] bank_choice_field,
  output logic interrupt_master_enable,
  output logic halt_mode,
  output logic stop_mode
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_EVAL = 4'b0100,
    ST_RUN = 4'b1000
  } state_e;

  typedef struct packed {
    state_e state;
    logic [3:0] op;
    logic [2:0] mode;
    logic [2:0] bitn;
    logic [7:0] ofs;
    logic [cpu_ctl_pkg::PC_W-1:0] pc;
    logic [2:0] len;
    logic [cpu_ctl_pkg::CNT_W-1:0] c_nm;
    logic [cpu_ctl_pkg::CNT_W-1:0] c_m;
    logic [cpu_ctl_pkg::CNT_W-1:0] cyc;
    logic taken;
    logic [7:0] data;
    logic [7:0] sw;
    logic busy;
    logic done;
    logic [cpu_ctl_pkg::PC_W-1:0] next_pc;
    logic skip;
    logic mem_rd;
    logic mem_wr;
    logic [cpu_ctl_pkg::PC_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic acc_wr;
    logic [7:0] acc_wdata;
    logic halt;
    logic stop;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [2:0] t_len;
  logic [cpu_ctl_pkg::CNT_W-1:0] t_nm;
  logic [cpu_ctl_pkg::CNT_W-1:0] t_m;
  logic t_mem;

  instr_timing u_timing (
    .op(op),
    .mode(mode),
    .prog_area(prog_area),
    .len(t_len),
    .clk_nm(t_nm),
    .clk_m(t_m),
    .needs_mem(t_mem)
  );

  function automatic logic [cpu_ctl_pkg::PC_W-1:0] pc_after(
    input logic [cpu_ctl_pkg::PC_W-1:0] pc,
    input logic [2:0] len,
    input logic [7:0] ofs,
    input logic take
  );
    logic [cpu_ctl_pkg::PC_W-1:0] disp;
    disp = take ? {{(cpu_ctl_pkg::PC_W-8){ofs[7]}}, ofs} : '0;
    return pc + {{(cpu_ctl_pkg::PC_W-3){1'b0}}, len} + disp;
  endfunction : pc_after

  function automatic logic bit_cond(input logic [3:0] op, input logic bitv);
    return (op == cpu_ctl_pkg::OP_BR_CLR) ? !bitv : bitv;
  endfunction : bit_cond

  function automatic logic skip_cond(input logic [3:0] op, input logic [7:0] sw);
    logic carry;
    logic zero;
    carry = sw[cpu_ctl_pkg::SW_CARRY];
    zero = sw[cpu_ctl_pkg::SW_ZERO];
    case (op)
      cpu_ctl_pkg::OP_SK_CARRY: return carry;
      cpu_ctl_pkg::OP_SK_NCARRY: return !carry;
      cpu_ctl_pkg::OP_SKZ: return zero;
      cpu_ctl_pkg::OP_SKNZ: return !zero;
      cpu_ctl_pkg::OP_SKH: return !(zero || carry);
      cpu_ctl_pkg::OP_SKNH: return zero || carry;
      default: return 1'b0;
    endcase
  endfunction : skip_cond

  function automatic logic is_skip(input logic [3:0] op);
    return (op >= cpu_ctl_pkg::OP_SK_CARRY) && (op <= cpu_ctl_pkg::OP_SKNH);
  endfunction : is_skip

  function automatic logic is_bit(input logic [3:0] op);
    return (op == cpu_ctl_pkg::OP_BR_CLR) || (op == cpu_ctl_pkg::OP_BR_SET);
  endfunction : is_bit

  function automatic logic [cpu_ctl_pkg::CNT_W-1:0] target(input state_s s);
    return s.taken ? s.c_m : s.c_nm;
  endfunction : target

  // Effects other than the memory write-back land together with the done pulse, in the last counted clock
  function automatic state_s finish(input state_s s);
    state_s f;
    f = s;
    f.state = ST_IDLE;
    f.busy = 1'b0;
    f.done = 1'b1;
    f.cyc = '0;
    f.next_pc = pc_after(s.pc, s.len, s.ofs, s.taken && is_bit(s.op));
    f.skip = is_skip(s.op) && s.taken;
    if (s.op == cpu_ctl_pkg::OP_BR_SET && s.taken) begin
      if (s.mode == cpu_ctl_pkg::M_ACC) begin
        f.acc_wr = 1'b1;
        f.acc_wdata = s.data & ~(8'h01 << s.bitn);
      end
      if (s.mode == cpu_ctl_pkg::M_STAT) begin
        f.sw[s.bitn] = 1'b0;
      end
    end
    case (s.op)
      cpu_ctl_pkg::OP_SEL: begin
        f.sw[cpu_ctl_pkg::SW_BANK1] = s.bitn[1];
        f.sw[cpu_ctl_pkg::SW_BANK0] = s.bitn[0];
      end
      cpu_ctl_pkg::OP_INT_ON: f.sw[cpu_ctl_pkg::SW_INTEN] = 1'b1;
      cpu_ctl_pkg::OP_INT_OFF: f.sw[cpu_ctl_pkg::SW_INTEN] = 1'b0;
      cpu_ctl_pkg::OP_HALT: f.halt = 1'b1;
      cpu_ctl_pkg::OP_STOP: f.stop = 1'b1;
      default: f.halt = s.halt;
    endcase
    return f;
  endfunction : finish

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.skip = 1'b0;
    nxt_st.mem_rd = 1'b0;
    nxt_st.mem_wr = 1'b0;
    nxt_st.acc_wr = 1'b0;
    // Wake first so a mode entry in the same cycle still sticks
    if (wake) begin
      nxt_st.halt = 1'b0;
      nxt_st.stop = 1'b0;
    end
    // Datapath status loads yield to this block's own updates
    if (sw_ld) begin
      nxt_st.sw = sw_wdata;
    end
    case (st_ff.state)
      ST_IDLE: begin
        if (start) begin
          nxt_st.op = op;
          nxt_st.mode = mode;
          nxt_st.bitn = bit_sel;
          nxt_st.ofs = rel_ofs;
          nxt_st.pc = instr_addr;
          nxt_st.len = t_len;
          nxt_st.c_nm = t_nm;
          nxt_st.c_m = t_m;
          nxt_st.cyc = cpu_ctl_pkg::CLK_ONE;
          nxt_st.data = acc_in;
          nxt_st.taken = 1'b0;
          if (t_mem) begin
            nxt_st.mem_rd = 1'b1;
            nxt_st.mem_addr = eff_addr;
            nxt_st.state = ST_READ;
            nxt_st.busy = 1'b1;
          end else begin
            if (is_bit(op)) begin
              nxt_st.taken = (mode == cpu_ctl_pkg::M_ACC) ?
                bit_cond(op, acc_in[bit_sel]) : bit_cond(op, nxt_st.sw[bit_sel]);
            end else begin
              nxt_st.taken = skip_cond(op, nxt_st.sw);
            end
            if (target(nxt_st) == cpu_ctl_pkg::CLK_ONE) begin
              nxt_st = finish(nxt_st);
            end else begin
              nxt_st.state = ST_RUN;
              nxt_st.busy = 1'b1;
            end
          end
        end
      end
      ST_READ: begin
        nxt_st.cyc = st_ff.cyc + cpu_ctl_pkg::CLK_ONE;
        nxt_st.state = ST_EVAL;
      end
      ST_EVAL: begin
        nxt_st.data = mem_rdata;
        nxt_st.taken = bit_cond(st_ff.op, mem_rdata[st_ff.bitn]);
        // Read-modify-write of the whole byte; other bits are written back unchanged
        if (st_ff.op == cpu_ctl_pkg::OP_BR_SET && nxt_st.taken) begin
          nxt_st.mem_wr = 1'b1;
          nxt_st.mem_wdata = mem_rdata & ~(8'h01 << st_ff.bitn);
        end
        nxt_st.cyc = st_ff.cyc + cpu_ctl_pkg::CLK_ONE;
        if (nxt_st.cyc == target(nxt_st)) begin
          nxt_st = finish(nxt_st);
        end else begin
          nxt_st.state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_st.cyc = st_ff.cyc + cpu_ctl_pkg::CLK_ONE;
        if (nxt_st.cyc == target(st_ff)) begin
          nxt_st = finish(nxt_st);
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.sw <= cpu_ctl_pkg::SW_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    busy = st_ff.busy;
    done = st_ff.done;
    next_pc = st_ff.next_pc;
    skip_next = st_ff.skip;
    mem_rd = st_ff.mem_rd;
    mem_wr = st_ff.mem_wr;
    mem_addr = st_ff.mem_addr;
    mem_wdata = st_ff.mem_wdata;
    acc_wr = st_ff.acc_wr;
    acc_wdata = st_ff.acc_wdata;
    program_status_word = st_ff.sw;
    bank_choice_field = {st_ff.sw[cpu_ctl_pkg::SW_BANK1], st_ff.sw[cpu_ctl_pkg::SW_BANK0]};
    interrupt_master_enable = st_ff.sw[cpu_ctl_pkg::SW_INTEN];
    halt_mode = st_ff.halt;
    stop_mode = st_ff.stop;
  end

  // Checking helper: counted clocks since acceptance
  logic [cpu_ctl_pkg::CNT_W-1:0] seen_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ff <= '0;
    end else if (ce) begin
      if (st_ff.state == ST_IDLE && start) begin
        seen_ff <= cpu_ctl_pkg::CLK_ONE;
      end else if (st_ff.busy) begin
        seen_ff <= seen_ff + cpu_ctl_pkg::CLK_ONE;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bit_short_len: assert property (
    done && is_bit(st_ff.op)
    && (st_ff.mode == cpu_ctl_pkg::M_ACC || st_ff.mode == cpu_ctl_pkg::M_PTR)
    |-> next_pc == pc_after(st_ff.pc, 3'h3, st_ff.ofs, st_ff.taken))
    else $error("short bit branch target wrong");
  a_bit_long_len: assert property (
    done && is_bit(st_ff.op)
    && !(st_ff.mode == cpu_ctl_pkg::M_ACC || st_ff.mode == cpu_ctl_pkg::M_PTR)
    |-> next_pc == pc_after(st_ff.pc, 3'h4, st_ff.ofs, st_ff.taken))
    else $error("long bit branch target wrong");
  a_direct_clocks: assert property (
    done && is_bit(st_ff.op) && st_ff.mode <= cpu_ctl_pkg::M_STAT
    |-> seen_ff == (st_ff.taken ? 4'h5 : 4'h3))
    else $error("direct bit branch clock count wrong");
  a_pm_clocks: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_BR_CLR && st_ff.mode == cpu_ctl_pkg::M_ESHL
    && st_ff.c_nm == 4'h7
    |-> seen_ff == (st_ff.taken ? 4'h8 : 4'h7))
    else $error("program memory clock count wrong");
  a_mem_clear: assert property (
    mem_wr |-> st_ff.op == cpu_ctl_pkg::OP_BR_SET && !mem_wdata[st_ff.bitn]
    && mem_addr == $past(mem_addr, 2) && $past(mem_rd, 2))
    else $error("bit clear write-back wrong");
  a_stat_clear: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_BR_SET && st_ff.mode == cpu_ctl_pkg::M_STAT && st_ff.taken
    |-> !program_status_word[st_ff.bitn])
    else $error("status bit not cleared");
  a_acc_clear: assert property (
    acc_wr |-> done && !acc_wdata[st_ff.bitn] && st_ff.taken)
    else $error("accumulator bit not cleared");
  a_skip_carry: assert property (
    ce && st_ff.state == ST_IDLE && start && op == cpu_ctl_pkg::OP_SK_CARRY && !sw_ld
    |=> done && skip_next == $past(program_status_word[cpu_ctl_pkg::SW_CARRY])
    && next_pc == $past(instr_addr) + 20'h00002)
    else $error("carry skip wrong");
  a_skip_nocarry: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_SK_NCARRY
    |-> skip_next == !program_status_word[cpu_ctl_pkg::SW_CARRY])
    else $error("no-carry skip wrong");
  a_bank_load: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_SEL |-> bank_choice_field == st_ff.bitn[1:0] && seen_ff == 4'h1)
    else $error("bank select wrong");
  a_inten_set: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_INT_ON |-> interrupt_master_enable && seen_ff == 4'h4)
    else $error("interrupt enable wrong");
  a_inten_clear: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_INT_OFF |-> !interrupt_master_enable && seen_ff == 4'h4)
    else $error("interrupt disable wrong");
  a_halt_enter: assert property (
    done && st_ff.op == cpu_ctl_pkg::OP_HALT |-> halt_mode && seen_ff == 4'h3)
    else $error("halt entry wrong");
endmodule : bit_branch_skip_cpu_control

// [data_mem_model.sv]
`timescale 1ns/100ps
module data_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [cpu_ctl_pkg::PC_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [256];
  int wr_cnt;

  // Plain always so the bench may preload bytes; only 256 bytes decoded
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 8'h00;
      wr_cnt <= 0;
    end else begin
      // Read data is good for one cycle only, then the bus keeps toggling
      if (mem_rd) begin
        mem_rdata <= mem[mem_addr[7:0]];
      end else begin
        mem_rdata <= ~mem_rdata;
      end
      if (mem_wr) begin
        mem[mem_addr[7:0]] <= mem_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
endmodule : data_mem_model

// [bit_branch_skip_cpu_control_bench.sv]
`timescale 1ns/100ps
module bit_branch_skip_cpu_control_bench;
  typedef struct {
    logic [3:0] op;
    logic [2:0] mode;
    logic [2:0] b;
    logic [7:0] ofs, acc, sw, mem;
    logic pa;
    int len, n;
    logic skip;
  } row_s;
  localparam int N_ROWS = 30;
  localparam logic [19:0] PC0 = 20'h01000;
  row_s rows[N_ROWS] = '{
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_SADDR, 3'h1, 8'h10, 8'h00, 8'h00, 8'hfd, 0, 4, 5, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_SADDR, 3'h1, 8'h10, 8'h00, 8'h00, 8'h02, 0, 4, 3, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_SFR, 3'h7, 8'h80, 8'h00, 8'h00, 8'h7f, 0, 4, 5, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_ACC, 3'h0, 8'hf0, 8'hfe, 8'h00, 8'h01, 0, 3, 5, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_STAT, 3'h0, 8'h20, 8'h00, 8'h01, 8'h00, 0, 4, 3, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_PTR, 3'h2, 8'h05, 8'h00, 8'h00, 8'hfb, 0, 3, 5, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_PTR, 3'h2, 8'h05, 8'h00, 8'h00, 8'hfb, 1, 3, 7, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_PTR, 3'h2, 8'h05, 8'h00, 8'h00, 8'h04, 1, 3, 6, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_ESHL, 3'h3, 8'h40, 8'h00, 8'h00, 8'h08, 0, 4, 4, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_ESHL, 3'h3, 8'h40, 8'h00, 8'h00, 8'h00, 0, 4, 6, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_ESHL, 3'h3, 8'h40, 8'h00, 8'h00, 8'h00, 1, 4, 8, 0},
    '{cpu_ctl_pkg::OP_BR_CLR, cpu_ctl_pkg::M_ESHL, 3'h3, 8'h40, 8'h00, 8'h00, 8'h08, 1, 4, 7, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_SADDR, 3'h1, 8'h7f, 8'h00, 8'h00, 8'h02, 0, 4, 5, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_SADDR, 3'h1, 8'h7f, 8'h00, 8'h00, 8'hfd, 0, 4, 3, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_SFR, 3'h7, 8'hff, 8'h00, 8'h00, 8'h80, 0, 4, 5, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_ACC, 3'h5, 8'h02, 8'h20, 8'h00, 8'h00, 0, 3, 5, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_STAT, 3'h4, 8'h02, 8'h00, 8'h51, 8'h00, 0, 4, 5, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_PTR, 3'h6, 8'h81, 8'h00, 8'h00, 8'hc0, 0, 3, 5, 0},
    '{cpu_ctl_pkg::OP_BR_SET, cpu_ctl_pkg::M_ESHL, 3'h0, 8'h03, 8'h00, 8'h00, 8'h01, 0, 4, 6, 0},
    '{cpu_ctl_pkg::OP_SK_CARRY, 3'h0, 3'h0, 8'h00, 8'h00, 8'h01, 8'h00, 0, 2, 1, 1},
    '{cpu_ctl_pkg::OP_SK_CARRY, 3'h0, 3'h0, 8'h00, 8'h00, 8'h40, 8'h00, 0, 2, 1, 0},
    '{cpu_ctl_pkg::OP_SK_NCARRY, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 0, 2, 1, 1},
    '{cpu_ctl_pkg::OP_SKZ, 3'h0, 3'h0, 8'h00, 8'h00, 8'h40, 8'h00, 0, 2, 1, 1},
    '{cpu_ctl_pkg::OP_SKNZ, 3'h0, 3'h0, 8'h00, 8'h00, 8'h40, 8'h00, 0, 2, 1, 0},
    '{cpu_ctl_pkg::OP_SKH, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 0, 2, 1, 1},
    '{cpu_ctl_pkg::OP_SKNH, 3'h0, 3'h0, 8'h00, 8'h00, 8'h01, 8'h00, 0, 2, 1, 1},
    '{cpu_ctl_pkg::OP_SEL, 3'h0, 3'h2, 8'h00, 8'h00, 8'hff, 8'h00, 0, 2, 1, 0},
    '{cpu_ctl_pkg::OP_INT_ON, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 0, 3, 4, 0},
    '{cpu_ctl_pkg::OP_INT_OFF, 3'h0, 3'h0, 8'h00, 8'h00, 8'h80, 8'h00, 0, 3, 4, 0},
    '{cpu_ctl_pkg::OP_HALT, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 0, 2, 3, 0}
  };
  logic clk = 0, rst_n = 0, ce = 1, start = 0, prog_area = 0, sw_ld = 0, wake = 0;
  logic [3:0] op = 4'h0;
  logic [2:0] mode = 3'h0, bit_sel = 3'h0;
  logic [7:0] rel_ofs = 8'h00, acc_in = 8'h00, sw_wdata = 8'h00, mem_rdata;
  logic [19:0] instr_addr = PC0, eff_addr = 20'h00040, next_pc, mem_addr;
  logic busy, done, skip_next, mem_rd, mem_wr, acc_wr, interrupt_master_enable;
  logic halt_mode, stop_mode;
  logic [7:0] mem_wdata, acc_wdata, program_status_word;
  logic [1:0] bank_choice_field;
  int error_cnt = 0, n_checks = 0, cyc = 0, k, cnt;
  row_s sel_row;

  bit_branch_skip_cpu_control dut_u (.clk, .rst_n, .ce, .start, .op, .mode, .bit_sel, .rel_ofs,
    .instr_addr, .eff_addr, .prog_area, .acc_in, .sw_ld, .sw_wdata, .wake, .mem_rdata, .busy,
    .done, .next_pc, .skip_next, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .acc_wr, .acc_wdata,
    .program_status_word, .bank_choice_field, .interrupt_master_enable, .halt_mode, .stop_mode);
  data_mem_model mem_u (.clk, .rst_n, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

  always #10 clk = ~clk;

  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_n(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_n

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Counts from the cycle after the accepting edge; gives up after 12
  task automatic wait_done(output int n);
    n = 1;
    #1;
    while (done !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_done

  task automatic run(input row_s r);
    logic tb, take, clr, mm;
    logic [7:0] epsw, emem;
    logic [19:0] epc;
    int w0, n;
    tb = (r.mode == cpu_ctl_pkg::M_ACC) ? r.acc[r.b] :
         (r.mode == cpu_ctl_pkg::M_STAT) ? r.sw[r.b] : r.mem[r.b];
    take = (r.op == cpu_ctl_pkg::OP_BR_CLR) ? !tb : tb;
    take = take && (r.op == cpu_ctl_pkg::OP_BR_CLR || r.op == cpu_ctl_pkg::OP_BR_SET);
    clr = take && r.op == cpu_ctl_pkg::OP_BR_SET;
    mm = !(r.mode inside {cpu_ctl_pkg::M_ACC, cpu_ctl_pkg::M_STAT});
    epsw = r.sw;
    if (clr && r.mode == cpu_ctl_pkg::M_STAT) epsw[r.b] = 1'b0;
    if (r.op == cpu_ctl_pkg::OP_INT_ON) epsw[7] = 1'b1;
    if (r.op == cpu_ctl_pkg::OP_INT_OFF) epsw[7] = 1'b0;
    if (r.op == cpu_ctl_pkg::OP_SEL) {epsw[5], epsw[3]} = r.b[1:0];
    emem = (clr && mm) ? (r.mem & ~(8'h01 << r.b)) : r.mem;
    epc = PC0 + 20'(r.len) + (take ? {{12{r.ofs[7]}}, r.ofs} : 20'h0);
    w0 = mem_u.wr_cnt;
    @(posedge clk);
    mem_u.mem[8'h40] = r.mem;
    sw_ld <= 1'b1;
    sw_wdata <= r.sw;
    wake <= 1'b1;
    @(posedge clk);
    sw_ld <= 1'b0;
    wake <= 1'b0;
    start <= 1'b1;
    op <= r.op;
    mode <= r.mode;
    bit_sel <= r.b;
    rel_ofs <= r.ofs;
    acc_in <= r.acc;
    prog_area <= r.pa;
    @(posedge clk);
    start <= 1'b0;
    wait_done(n);
    chk_n("cycles", r.n, n);
    chk("next_pc", epc, next_pc);
    chk("skip_next", r.skip, skip_next);
    chk("acc_wr", clr && r.mode == cpu_ctl_pkg::M_ACC, acc_wr);
    if (acc_wr === 1'b1) chk("acc_wdata", r.acc & ~(8'h01 << r.b), acc_wdata);
    chk("psw", epsw, program_status_word);
    chk("bank", {epsw[5], epsw[3]}, bank_choice_field);
    chk("ie", epsw[7], interrupt_master_enable);
    chk("halt", r.op == cpu_ctl_pkg::OP_HALT, halt_mode);
    chk("mem", emem, mem_u.mem[8'h40]);
    chk_n("writes", (clr && mm) ? 1 : 0, mem_u.wr_cnt - w0);
  endtask : run

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk("reset psw", 8'h00, program_status_word);
    chk("reset busy", 1'b0, busy);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < N_ROWS; i++) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    sel_row = rows[26];
    for (int b = 0; b < 4; b++) begin
      sel_row.b = 3'(b);
      run(sel_row);
    end
    sel_row = rows[29];
    sel_row.op = cpu_ctl_pkg::OP_STOP;
    run(sel_row);
    chk("stop", 1'b1, stop_mode);
    $display("bank and stop test done");
    // Start during busy must be dropped; frozen clock enable stretches the count
    @(posedge clk);
    start <= 1'b1;
    op <= cpu_ctl_pkg::OP_INT_ON;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    wait_done(k);
    chk_n("stretched", 2, k);
    chk("ie set", 1'b1, interrupt_master_enable);
    cnt = 0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) cnt++;
    end
    chk_n("refused start", 0, cnt);
    $display("refusal test done");
    @(posedge clk);
    start <= 1'b1;
    op <= cpu_ctl_pkg::OP_INT_ON;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("mid reset busy", 1'b0, busy);
    chk("mid reset ie", 1'b0, interrupt_master_enable);
    @(posedge clk);
    rst_n <= 1'b1;
    run(rows[12]);
    $display("mid reset test done");
    conclude();
  end
endmodule : bit_branch_skip_cpu_control_bench
